/* design/tsr_pkg.sv */
/*
 Shared constants and carriers for the touch sample readout port.
 Assumes a byte-addressed register access port, one clock and a single acquisition source.
*/
package tsr_pkg;
  localparam logic [7:0] ADDR_X_MSB = 8'h4d;
  localparam logic [7:0] ADDR_X_LSB = 8'h4e;
  localparam logic [7:0] ADDR_Y_MSB = 8'h4f;
  localparam logic [7:0] ADDR_Y_LSB = 8'h50;
  localparam logic [7:0] ADDR_Z = 8'h51;
  localparam logic [7:0] ADDR_FRACT = 8'h56;
  localparam logic [7:0] ADDR_DRIVE = 8'h58;
  localparam logic [7:0] ADDR_FIXED = 8'h5b;
  localparam logic [7:0] ADDR_PACKED = 8'h5c;
  localparam logic [7:0] PACKED_LAST = 8'h5f;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_FRACT = 3'h0;
  localparam logic RST_DRIVE = 1'b0;
  localparam int FRACT_LSB = 0;
  localparam int DRIVE_BIT = 0;

  localparam logic [2:0] MODE_XYZ = 3'h0;
  localparam logic [2:0] MODE_XY = 3'h1;
  localparam logic [2:0] MODE_X = 3'h2;
  localparam logic [2:0] MODE_Y = 3'h3;
  localparam logic [2:0] MODE_Z = 3'h4;

  localparam logic [2:0] LEN_XYZ = 3'h4;
  localparam logic [2:0] LEN_XY = 3'h3;
  localparam logic [2:0] LEN_ONE = 3'h2;
  localparam logic [2:0] LEN_Z = 3'h1;
  localparam logic [2:0] LEN_NONE = 3'h0;

  localparam int FIFO_DEPTH = 8;
  localparam int SAMPLE_W = 32;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [7:0] z;
  } tsr_sample_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tsr_reg_req_t;
endpackage

/* design/tsr_fifo.sv */
/*
 Sample FIFO with valid/ready on both sides and parameterised width and depth.
 Assumes DEPTH is a power of two; push and pop in one cycle are both honoured unless full, when only the pop is taken, or empty, when only the push is.
*/
`timescale 1ns/1ps
`default_nettype none
module tsr_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready_o = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  assign count_o = count;

  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; only written words are ever read out
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* design/tsr_byte_pack.sv */
/*
 Picks one byte of a packed sample by operating mode and byte index.
 Assumes the caller keeps the index below the returned length.
*/
`timescale 1ns/1ps
`default_nettype none
module tsr_byte_pack (
  input wire logic [2:0] mode_i,
  input wire tsr_pkg::tsr_sample_t sample_i,
  input wire logic [1:0] idx_i,
  output logic [7:0] byte_o,
  output logic [2:0] len_o
);
  logic [7:0] xyz [4];

  always_comb begin
    xyz[0] = sample_i.x[11:4];
    xyz[1] = {sample_i.x[3:0], sample_i.y[11:8]};
    xyz[2] = sample_i.y[7:0];
    xyz[3] = sample_i.z;
    byte_o = 8'h00;
    len_o = tsr_pkg::LEN_NONE;
    case (mode_i)
      tsr_pkg::MODE_XYZ: begin
        len_o = tsr_pkg::LEN_XYZ;
        byte_o = xyz[idx_i];
      end
      tsr_pkg::MODE_XY: begin
        len_o = tsr_pkg::LEN_XY;
        byte_o = xyz[idx_i];
      end
      tsr_pkg::MODE_X: begin
        len_o = tsr_pkg::LEN_ONE;
        byte_o = idx_i[0] ? {sample_i.x[3:0], 4'h0} : sample_i.x[11:4];
      end
      tsr_pkg::MODE_Y: begin
        len_o = tsr_pkg::LEN_ONE;
        byte_o = idx_i[0] ? {sample_i.y[3:0], 4'h0} : sample_i.y[11:4];
      end
      tsr_pkg::MODE_Z: begin
        len_o = tsr_pkg::LEN_Z;
        byte_o = sample_i.z;
      end
      default: begin
        len_o = tsr_pkg::LEN_NONE;
        byte_o = 8'h00;
      end
    endcase
  end
endmodule
`default_nettype wire

/* design/tsr_readout.sv */
/*
 Touch sample readout port: buffers acquired samples and hands them to the host as
 packed bytes through the register access port, plus the pressure fraction and
 driver current limit settings.
 Assumes the register access port and the acquisition logic share ref_clk_i, and that
 the operating mode comes from the touch control register held elsewhere.
*/
// How it works
// - Read-only byte port drains FIFO, resets 0x00
// - Byte layout follows the acquisition operating mode
// - Each sample is one packed byte group
// - Incrementing and fixed-address reads both work
// - Mode 000 four bytes, 001 first three
// - Modes 010/011 two bytes, 100 one byte
// - Three-bit pressure fraction selector, reset zero
// - Drive bit picks 20 or 50 mA
// - Packed register usable only in 000/001
// - Fixed port: same layout, one address
// - X result readable in every mode
`timescale 1ns/1ps
`default_nettype none
module tsr_readout (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] acquisition_op_select_i,
  input wire logic smp_valid_i,
  output logic smp_ready_o,
  input wire tsr_pkg::tsr_sample_t smp_i,
  input wire tsr_pkg::tsr_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic [3:0] sample_count_o,
  output logic [2:0] pressure_fraction_select_o,
  output logic drive_high_current_o
);
  tsr_pkg::tsr_sample_t head;
  logic [tsr_pkg::SAMPLE_W-1:0] head_bits;
  logic head_valid;
  logic pop;
  logic [7:0] pack_byte;
  logic [2:0] pack_len;
  logic [1:0] byte_idx, next_byte_idx;
  logic [2:0] last_mode;
  logic [7:0] next_rdata;
  logic [2:0] next_fract;
  logic next_drive;
  logic mode_chg, packed_addr, packed_ok, fixed_addr, stream_rd, last_byte;

  // Back-pressure reaches the acquisition side through smp_ready_o
  tsr_fifo #(
    .W(tsr_pkg::SAMPLE_W),
    .DEPTH(tsr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(smp_valid_i),
    .in_ready_o(smp_ready_o),
    .in_data_i(smp_i),
    .out_valid_o(head_valid),
    .out_ready_i(pop),
    .out_data_o(head_bits),
    .count_o(sample_count_o)
  );
  // An empty buffer shows zeros, so the result registers read their reset value
  assign head = head_valid ? tsr_pkg::tsr_sample_t'(head_bits) : '0;

  tsr_byte_pack u_pack (
    .mode_i(acquisition_op_select_i),
    .sample_i(head),
    .idx_i(byte_idx),
    .byte_o(pack_byte),
    .len_o(pack_len)
  );

  always_comb begin
    mode_chg = (acquisition_op_select_i != last_mode);
    fixed_addr = (reg_req_i.addr == tsr_pkg::ADDR_FIXED);
    packed_addr = (reg_req_i.addr >= tsr_pkg::ADDR_PACKED)
                  && (reg_req_i.addr <= tsr_pkg::PACKED_LAST);
    packed_ok = packed_addr && ((acquisition_op_select_i == tsr_pkg::MODE_XYZ)
                || (acquisition_op_select_i == tsr_pkg::MODE_XY));
    // Both ports walk the same internal index, so an incrementing read across
    // the packed window and repeated reads at one address give the same bytes
    stream_rd = reg_req_i.rd && (fixed_addr || packed_ok) && head_valid
                && (pack_len != tsr_pkg::LEN_NONE) && !mode_chg;
    last_byte = ({1'b0, byte_idx} == pack_len - 3'h1);
    pop = stream_rd && last_byte;
    if (mode_chg || pop) begin
      next_byte_idx = 2'h0;
    end else if (stream_rd) begin
      next_byte_idx = byte_idx + 2'h1;
    end else begin
      next_byte_idx = byte_idx;
    end
  end

  always_comb begin
    next_rdata = reg_rdata_o;
    if (reg_req_i.rd) begin
      next_rdata = 8'h00;
      case (1'b1)
        stream_rd: next_rdata = pack_byte;
        reg_req_i.addr == tsr_pkg::ADDR_X_MSB: next_rdata = {4'h0, head.x[11:8]};
        reg_req_i.addr == tsr_pkg::ADDR_X_LSB: next_rdata = head.x[7:0];
        reg_req_i.addr == tsr_pkg::ADDR_Y_MSB: next_rdata = {4'h0, head.y[11:8]};
        reg_req_i.addr == tsr_pkg::ADDR_Y_LSB: next_rdata = head.y[7:0];
        reg_req_i.addr == tsr_pkg::ADDR_Z: next_rdata = head.z;
        reg_req_i.addr == tsr_pkg::ADDR_FRACT: next_rdata = {5'h00, pressure_fraction_select_o};
        reg_req_i.addr == tsr_pkg::ADDR_DRIVE: next_rdata = {7'h00, drive_high_current_o};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_fract = pressure_fraction_select_o;
    next_drive = drive_high_current_o;
    if (reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_FRACT) begin
      next_fract = reg_req_i.wdata[tsr_pkg::FRACT_LSB +: 3];
    end
    if (reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_DRIVE) begin
      next_drive = reg_req_i.wdata[tsr_pkg::DRIVE_BIT];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      byte_idx <= 2'h0;
      last_mode <= tsr_pkg::MODE_XYZ;
      reg_rdata_o <= tsr_pkg::RST_BYTE;
      pressure_fraction_select_o <= tsr_pkg::RST_FRACT;
      drive_high_current_o <= tsr_pkg::RST_DRIVE;
    end else begin
      byte_idx <= next_byte_idx;
      last_mode <= acquisition_op_select_i;
      reg_rdata_o <= next_rdata;
      pressure_fraction_select_o <= next_fract;
      drive_high_current_o <= next_drive;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_pop_last_byte: assert property (
    pop |-> ({1'b0, byte_idx} == pack_len - 3'h1))
    else $error("sample popped before its last byte");

  a_count_drops: assert property (
    pop && !(smp_valid_i && smp_ready_o) |=> sample_count_o == $past(sample_count_o) - 4'h1)
    else $error("sample count did not drop after last byte");

  a_index_advance: assert property (
    stream_rd && !last_byte |=> byte_idx == $past(byte_idx) + 2'h1)
    else $error("byte index did not advance");

  a_fixed_data: assert property (
    reg_req_i.rd && fixed_addr && stream_rd |=> reg_rdata_o == $past(pack_byte))
    else $error("fixed port returned wrong byte");

  a_packed_gate: assert property (
    reg_req_i.rd && packed_addr && acquisition_op_select_i > tsr_pkg::MODE_XY
    |-> !pop ##1 reg_rdata_o == 8'h00)
    else $error("packed register used in wrong mode");

  a_x_readable: assert property (
    reg_req_i.rd && reg_req_i.addr == tsr_pkg::ADDR_X_LSB |=> reg_rdata_o == $past(head.x[7:0]))
    else $error("x result not readable");

  a_mode0_pair: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XYZ && byte_idx == 2'h1
    |-> pack_byte == {head.x[3:0], head.y[11:8]} && pack_len == tsr_pkg::LEN_XYZ)
    else $error("mode 000 second byte wrong");

  a_short_modes: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_Z |-> pack_len == tsr_pkg::LEN_Z
    && pack_byte == head.z)
    else $error("mode 100 layout wrong");

  a_fract_write: assert property (
    reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_FRACT
    |=> pressure_fraction_select_o == $past(reg_req_i.wdata[2:0]))
    else $error("fraction selector not written");

  a_drive_write: assert property (
    reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_DRIVE
    |=> drive_high_current_o == $past(reg_req_i.wdata[0]) ##1 ($stable(drive_high_current_o)
    || $past(reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_DRIVE)))
    else $error("drive bit not written");

  a_rdata_hold: assert property (
    !reg_req_i.rd |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");

  a_empty_read: assert property (
    reg_req_i.rd && fixed_addr && !head_valid |=> reg_rdata_o == 8'h00)
    else $error("empty port returned a nonzero byte");

  a_empty_no_pop: assert property (
    !head_valid |-> !pop)
    else $error("pop from an empty buffer");

  a_pop_with_push: assert property (
    pop && smp_valid_i && smp_ready_o |=> $stable(sample_count_o))
    else $error("count moved on a push and pop together");

  // A mode change restarts the packed group, so a half-read sample is sent again whole
  a_mode_change_idx: assert property (
    mode_chg |=> byte_idx == 2'h0)
    else $error("mode change kept a stale byte index");

  a_illegal_mode: assert property (
    acquisition_op_select_i > tsr_pkg::MODE_Z
    |-> pack_len == tsr_pkg::LEN_NONE && !stream_rd)
    else $error("illegal mode produced stream bytes");

  a_idx_in_range: assert property (
    head_valid && pack_len != tsr_pkg::LEN_NONE && !mode_chg
    |-> {1'b0, byte_idx} < pack_len)
    else $error("byte index beyond the sample length");

  a_fixed_stream: assert property (
    reg_req_i.rd && fixed_addr && head_valid && pack_len != tsr_pkg::LEN_NONE && !mode_chg
    |-> stream_rd)
    else $error("fixed-address read did not stream");

  a_packed_stream: assert property (
    reg_req_i.rd && packed_ok && head_valid && pack_len != tsr_pkg::LEN_NONE && !mode_chg
    |-> stream_rd)
    else $error("incrementing read did not stream");

  a_mode0_first: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XYZ && byte_idx == 2'h0
    |-> pack_byte == head.x[11:4])
    else $error("mode 000 first byte wrong");

  a_mode0_third: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XYZ && byte_idx == 2'h2
    |-> pack_byte == head.y[7:0])
    else $error("mode 000 third byte wrong");

  a_mode0_fourth: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XYZ && byte_idx == 2'h3
    |-> pack_byte == head.z)
    else $error("mode 000 fourth byte wrong");

  a_mode1_len: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XY |-> pack_len == tsr_pkg::LEN_XY)
    else $error("mode 001 length wrong");

  a_mode1_second: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_XY && byte_idx == 2'h1
    |-> pack_byte == {head.x[3:0], head.y[11:8]})
    else $error("mode 001 second byte wrong");

  a_mode2_first: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_X && byte_idx == 2'h0
    |-> pack_byte == head.x[11:4] && pack_len == tsr_pkg::LEN_ONE)
    else $error("mode 010 first byte wrong");

  a_mode2_second: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_X && byte_idx == 2'h1
    |-> pack_byte == {head.x[3:0], 4'h0})
    else $error("mode 010 second byte wrong");

  a_mode3_first: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_Y && byte_idx == 2'h0
    |-> pack_byte == head.y[11:4] && pack_len == tsr_pkg::LEN_ONE)
    else $error("mode 011 first byte wrong");

  a_mode3_second: assert property (
    acquisition_op_select_i == tsr_pkg::MODE_Y && byte_idx == 2'h1
    |-> pack_byte == {head.y[3:0], 4'h0})
    else $error("mode 011 second byte wrong");

  a_fract_hold: assert property (
    !(reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_FRACT)
    |=> $stable(pressure_fraction_select_o))
    else $error("fraction selector changed without a write");

  a_drive_hold: assert property (
    !(reg_req_i.wr && reg_req_i.addr == tsr_pkg::ADDR_DRIVE)
    |=> $stable(drive_high_current_o))
    else $error("drive bit changed without a write");

  a_fract_read: assert property (
    reg_req_i.rd && reg_req_i.addr == tsr_pkg::ADDR_FRACT
    |=> reg_rdata_o == {5'h00, $past(pressure_fraction_select_o)})
    else $error("fraction selector read back wrong");

  a_drive_read: assert property (
    reg_req_i.rd && reg_req_i.addr == tsr_pkg::ADDR_DRIVE
    |=> reg_rdata_o == {7'h00, $past(drive_high_current_o)})
    else $error("drive bit read back wrong");

  a_refused_idx: assert property (
    reg_req_i.rd && packed_addr && !packed_ok && !mode_chg |=> $stable(byte_idx))
    else $error("refused packed read moved the index");

  a_packed_data: assert property (
    stream_rd && packed_addr |=> reg_rdata_o == $past(pack_byte))
    else $error("packed port returned wrong byte");

  a_x_msb: assert property (
    reg_req_i.rd && reg_req_i.addr == tsr_pkg::ADDR_X_MSB
    |=> reg_rdata_o == {4'h0, $past(head.x[11:8])})
    else $error("x result high nibble not readable");

  a_result_no_pop: assert property (
    reg_req_i.rd && !fixed_addr && !packed_addr |-> !pop)
    else $error("result register read popped a sample");

  c_pop_four: cover property (pop && acquisition_op_select_i == tsr_pkg::MODE_XYZ);
  c_pop_one: cover property (pop && acquisition_op_select_i == tsr_pkg::MODE_Z);
  c_fifo_full: cover property (!smp_ready_o ##1 pop);
  c_fixed_burst: cover property ((stream_rd && fixed_addr) [*4]);
endmodule
`default_nettype wire

/* tb/tsr_host.sv */
/*
 Host model: issues single-cycle register reads and writes on the readout port.
 Assumes it shares ref_clk_i with the design and drives just after the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module tsr_host (
  input wire logic ref_clk_i,
  output logic [17:0] req_o,
  input wire logic [7:0] rdata_i
);
  initial req_o = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    req_o = {2'b01, a, d};
    @(negedge ref_clk_i);
    req_o = '0;
  endtask
  // One gap cycle between requests keeps each strobe a clean pulse
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    req_o = {2'b10, a, 8'h00};
    @(negedge ref_clk_i);
    req_o = '0;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
/*
 Self-checking bench for the touch sample readout port.
 Assumes the host model in tsr_host and the design package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic smp_valid_i = 1'b0;
  logic [2:0] op_sel = 3'h0;
  tsr_pkg::tsr_sample_t smp = '0;
  logic [17:0] req;
  logic [7:0] rdata;
  logic [7:0] b;
  logic [3:0] cnt;
  logic [2:0] fract;
  logic drive;
  logic ready;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'h6727;
  tsr_pkg::tsr_sample_t q[$];

  tsr_readout u_tsr_readout (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .acquisition_op_select_i(op_sel), .smp_valid_i(smp_valid_i), .smp_ready_o(ready),
    .smp_i(smp), .reg_req_i(tsr_pkg::tsr_reg_req_t'(req)), .reg_rdata_o(rdata),
    .sample_count_o(cnt), .pressure_fraction_select_o(fract), .drive_high_current_o(drive));
  tsr_host u_tsr_host (.ref_clk_i(ref_clk_i), .req_o(req), .rdata_i(rdata));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  function automatic logic [7:0] exp_b(logic [2:0] m, tsr_pkg::tsr_sample_t s, int i);
    logic [11:0] c;
    c = (m == 3'h3) ? s.y : s.x;
    if (m == 3'h4 || i == 3) return s.z;
    if (i == 0) return c[11:4];
    if (i == 2) return s.y[7:0];
    return (m < 3'h2) ? {c[3:0], s.y[11:8]} : {c[3:0], 4'h0};
  endfunction

  function automatic int len(logic [2:0] m);
    return (m == 3'h0) ? 4 : (m == 3'h1) ? 3 : (m == 3'h4) ? 1 : 2;
  endfunction

  // Only samples offered while ready is high are expected back
  task automatic push();
    tsr_pkg::tsr_sample_t s;
    s = tsr_pkg::tsr_sample_t'($random(seed));
    @(negedge ref_clk_i);
    smp_valid_i = 1'b1;
    smp = s;
    if (ready === 1'b1) q.push_back(s);
    @(negedge ref_clk_i);
    smp_valid_i = 1'b0;
  endtask

  // Mode is settled two cycles before any stream read
  task automatic set_mode(input logic [2:0] m);
    @(negedge ref_clk_i);
    op_sel = m;
    repeat (2) @(negedge ref_clk_i);
  endtask

  task automatic take(input logic [7:0] a, input bit inc);
    tsr_pkg::tsr_sample_t s;
    logic [3:0] c;
    s = q.pop_front();
    c = cnt;
    for (int i = 0; i < len(op_sel); i++) begin
      u_tsr_host.rd(inc ? a + 8'(i) : a, b);
      chk("sample byte", exp_b(op_sel, s, i), b);
    end
    chk("count", {4'h0, c - 4'h1}, {4'h0, cnt});
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (3) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    u_tsr_host.rd(8'h56, b);
    chk("fraction reset", 8'h00, b);
    u_tsr_host.rd(8'h58, b);
    chk("drive reset", 8'h00, b);
    u_tsr_host.rd(8'h5b, b);
    chk("empty port", 8'h00, b);
    $display("reset test done");
    for (int n = 0; n < 8; n++) begin
      u_tsr_host.wr(8'h56, 8'(n));
      u_tsr_host.rd(8'h56, b);
      chk("fraction reg", 8'(n), b);
      chk("fraction pin", 8'(n), {5'h0, fract});
    end
    u_tsr_host.wr(8'h58, 8'h01);
    u_tsr_host.rd(8'h58, b);
    chk("drive reg", 8'h01, b);
    chk("drive pin", 8'h01, {7'h0, drive});
    u_tsr_host.wr(8'h58, 8'h00);
    chk("drive low", 8'h00, {7'h0, drive});
    $display("settings test done");
    for (int m = 0; m < 5; m++) begin
      set_mode(3'(m));
      push();
      push();
      u_tsr_host.rd(8'h4d, b);
      chk("x high", {4'h0, q[0].x[11:8]}, b);
      u_tsr_host.rd(8'h4e, b);
      chk("x low", q[0].x[7:0], b);
      u_tsr_host.rd(8'h4f, b);
      chk("y high", {4'h0, q[0].y[11:8]}, b);
      u_tsr_host.rd(8'h50, b);
      chk("y low", q[0].y[7:0], b);
      u_tsr_host.rd(8'h51, b);
      chk("z result", q[0].z, b);
      take(8'h5b, 1'b0);
      if (m < 2) begin
        take(8'h5c, 1'b1);
      end else begin
        u_tsr_host.rd(8'h5c, b);
        chk("packed refused", 8'h00, b);
        chk("no pop", 8'h01, {4'h0, cnt});
        take(8'h5b, 1'b0);
      end
      $display("mode %0d test done", m);
    end
    push();
    set_mode(3'h5);
    u_tsr_host.rd(8'h5b, b);
    chk("illegal mode", 8'h00, b);
    chk("illegal no pop", 8'h01, {4'h0, cnt});
    set_mode(3'h0);
    repeat (8) push();
    chk("full count", 8'h08, {4'h0, cnt});
    chk("full ready", 8'h00, {7'h0, ready});
    // The host drains the whole buffer from the one fixed address
    while (q.size() > 0) take(8'h5b, 1'b0);
    chk("drained", 8'h00, {4'h0, cnt});
    $display("fill and drain test done");
    stop_test();
  end
endmodule
`default_nettype wire
